// *** cch_core.sv ***
/*
 * Common command and status handler: executes decoded common commands,
 * keeps the standard event register and its enable mask, the lockout
 * state and the error queue count, and streams query answers.
 * Assumes the command parser upstream maps star and native command
 * forms to one code, and gives cmd_valid_i as a one-cycle pulse only
 * while rsp_busy_o is low. resetn_i is the power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none

module cch_core #(
    parameter int ERRQ_DEPTH = 16
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Decoded command
    input  wire logic       cmd_valid_i,
    input  wire logic [3:0] cmd_code_i,
    input  wire logic [7:0] cmd_arg_i,
    // Event sources, one-cycle pulses; ops_pending_i is a level
    input  wire logic       ev_req_ctrl_i,
    input  wire logic       ev_query_err_i,
    input  wire logic       ev_dev_err_i,
    input  wire logic       ev_exec_err_i,
    input  wire logic       ev_cmd_err_i,
    input  wire logic       ops_pending_i,
    input  wire logic       err_push_i,
    // Other status summary bits
    input  wire logic       ques_evt_i,
    input  wire logic       oper_evt_i,
    // Response stream
    output logic            rsp_valid_o,
    output logic [7:0]      rsp_data_o,
    output logic            rsp_last_o,
    output logic            rsp_busy_o,
    // Status and control
    output logic [7:0]      esr_o,
    output logic [7:0]      ese_o,
    output logic            esb_o,
    output logic [4:0]      err_count_o,
    output logic            status_clear_o,
    output logic            dev_clear_o,
    output logic            panel_lock_o
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    cch_rsp_if rsp ();

    cch_pkg::cch_cmd_t cmd;
    logic              go;
    logic [7:0]        esr_r;
    logic [7:0]        ese_r;
    logic [7:0]        ev_set;
    logic              opc_wait_r;
    logic [4:0]        errq_r;

    assign cmd = cch_pkg::cch_cmd_t'(cmd_code_i);
    assign go  = cmd_valid_i && !rsp.busy;

    // ----------------------------------------------------------------
    // Operation complete tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            opc_wait_r <= 1'b0;
        end else if (go && (cmd == cch_pkg::CCH_CMD_CLS ||
                            cmd == cch_pkg::CCH_CMD_DCL)) begin
            opc_wait_r <= 1'b0;
        end else if (go && cmd == cch_pkg::CCH_CMD_OPC) begin
            opc_wait_r <= 1'b1;
        end else if (!ops_pending_i) begin
            opc_wait_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Standard event register
    // ----------------------------------------------------------------
    always_comb begin
        ev_set = cch_pkg::CCH_BYTE_ZERO;
        ev_set[cch_pkg::CCH_EV_OPC] = opc_wait_r && !ops_pending_i;
        ev_set[cch_pkg::CCH_EV_RQC] = ev_req_ctrl_i;
        ev_set[cch_pkg::CCH_EV_QYE] = ev_query_err_i;
        ev_set[cch_pkg::CCH_EV_DDE] = ev_dev_err_i;
        ev_set[cch_pkg::CCH_EV_EXE] = ev_exec_err_i;
        ev_set[cch_pkg::CCH_EV_CME] = ev_cmd_err_i;
    end

    // Clearing commands zero the register, but a same-cycle event survives
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            esr_r <= cch_pkg::CCH_ESR_RST;
        end else if (go && (cmd == cch_pkg::CCH_CMD_CLS ||
                            cmd == cch_pkg::CCH_CMD_ESRQ)) begin
            esr_r <= ev_set;
        end else begin
            esr_r <= esr_r | ev_set;
        end
    end

    // ----------------------------------------------------------------
    // Enable mask
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ese_r <= cch_pkg::CCH_ESE_RST;
        end else if (go && cmd == cch_pkg::CCH_CMD_ESE) begin
            ese_r <= cmd_arg_i;
        end
        // Reset command not decoded here on purpose
    end

    // ----------------------------------------------------------------
    // Error queue occupancy
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            errq_r <= 5'h00;
        end else if (go && cmd == cch_pkg::CCH_CMD_CLS) begin
            errq_r <= {4'h0, err_push_i};
        end else if (err_push_i && errq_r < 5'(ERRQ_DEPTH)) begin
            errq_r <= errq_r + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            panel_lock_o   <= 1'b0;
            status_clear_o <= 1'b0;
            dev_clear_o    <= 1'b0;
        end else begin
            status_clear_o <= go && cmd == cch_pkg::CCH_CMD_CLS;
            dev_clear_o    <= go && cmd == cch_pkg::CCH_CMD_DCL;
            if (go && cmd == cch_pkg::CCH_CMD_LLO) begin
                panel_lock_o <= 1'b1;
            end else if (go && (cmd == cch_pkg::CCH_CMD_GTL ||
                                cmd == cch_pkg::CCH_CMD_DCL)) begin
                panel_lock_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            esr_o       <= cch_pkg::CCH_ESR_RST;
            ese_o       <= cch_pkg::CCH_ESE_RST;
            esb_o       <= 1'b0;
            err_count_o <= 5'h00;
        end else begin
            esr_o       <= esr_r;
            ese_o       <= ese_r;
            esb_o       <= |(esr_r & ese_r);
            err_count_o <= errq_r;
        end
    end

    // ----------------------------------------------------------------
    // Query dispatch
    // ----------------------------------------------------------------
    always_comb begin
        rsp.start = 1'b0;
        rsp.is_id = 1'b0;
        rsp.value = cch_pkg::CCH_BYTE_ZERO;
        if (go) begin
            case (cmd)
                cch_pkg::CCH_CMD_ESRQ: begin
                    rsp.start = 1'b1;
                    rsp.value = esr_r;
                end
                cch_pkg::CCH_CMD_ESEQ: begin
                    rsp.start = 1'b1;
                    rsp.value = ese_r;
                end
                cch_pkg::CCH_CMD_IDNQ: begin
                    rsp.start = 1'b1;
                    rsp.is_id = 1'b1;
                end
                default: rsp.start = 1'b0;
            endcase
        end
    end

    cch_rsp_fmt u_fmt (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .rsp      (rsp)
    );

    // Registered again so the top outputs come straight from flops
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= cch_pkg::CCH_BYTE_ZERO;
            rsp_last_o  <= 1'b0;
            rsp_busy_o  <= 1'b0;
        end else begin
            rsp_valid_o <= rsp.byte_valid;
            rsp_data_o  <= rsp.byte_data;
            rsp_last_o  <= rsp.last;
            // Start counts at once; the formatter flag rises an edge later
            rsp_busy_o  <= rsp.busy || rsp.byte_valid || rsp.start;
        end
    end

endmodule : cch_core

`default_nettype wire

// *** cch_core_monitor.sv ***
/*
 * Checker for the common command and status handler top ports.
 * Assumes one clock and the synchronous active-low power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none

module cch_core_monitor (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       resetn_i,
    // Commands and events
    input wire logic       cmd_valid_i,
    input wire logic [3:0] cmd_code_i,
    input wire logic [7:0] cmd_arg_i,
    input wire logic       ev_req_ctrl_i,
    input wire logic       ev_query_err_i,
    input wire logic       ev_dev_err_i,
    input wire logic       ev_exec_err_i,
    input wire logic       ev_cmd_err_i,
    input wire logic       ops_pending_i,
    // Responses and status
    input wire logic       rsp_valid_o,
    input wire logic       rsp_busy_o,
    input wire logic [7:0] esr_o,
    input wire logic [7:0] ese_o,
    input wire logic       esb_o,
    input wire logic       status_clear_o,
    input wire logic       dev_clear_o,
    input wire logic       panel_lock_o
);
    logic [4:0] ev_w;

    assign ev_w = {ev_cmd_err_i, ev_exec_err_i, ev_dev_err_i,
                   ev_query_err_i, ev_req_ctrl_i};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_take(logic [3:0] c);
        cmd_valid_i && !rsp_busy_o && cmd_code_i == c;
    endsequence
    sequence s_quiet;
        ev_w == 5'h00;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    chk_por_values: assert property (
        $rose(resetn_i) |-> ese_o == 8'h00 && esr_o == 8'h80)
        else $error("power-on values wrong");
    chk_ese_store: assert property (
        s_take(4'h3) |-> ##3 ese_o == $past(cmd_arg_i, 3))
        else $error("enable mask not stored");
    chk_ese_keep_rst: assert property (
        s_take(4'hA) |=> $stable(ese_o) [*4])
        else $error("reset command changed mask");
    chk_esb_summary: assert property (
        ($stable(esr_o) && $stable(ese_o)) [*3]
        |-> esb_o == |(esr_o & ese_o))
        else $error("summary bit wrong");
    chk_event_latch: assert property (
        |ev_w |-> ##3 (esr_o[5:1] & $past(ev_w, 3)) == $past(ev_w, 3))
        else $error("event not latched");
    chk_esr_clear: assert property (
        (s_take(4'h5) or s_take(4'h1)) ##0 s_quiet [*3]
        |-> ##1 esr_o == 8'h00)
        else $error("event register not cleared");
    chk_cls_pulse: assert property (
        s_take(4'h1) |=> ##[0:1] (status_clear_o ##1 !status_clear_o))
        else $error("status clear pulse missing");
    chk_dcl_pulse: assert property (
        s_take(4'h2) |=> dev_clear_o ##1 !dev_clear_o)
        else $error("device clear pulse missing");
    chk_lock_on: assert property (
        s_take(4'h8) |-> ##3 panel_lock_o)
        else $error("lockout not set");
    chk_lock_off: assert property (
        (s_take(4'h6) or s_take(4'h2)) |-> ##3 !panel_lock_o)
        else $error("lockout not released");
    chk_rsp_first: assert property (
        (s_take(4'h4) or s_take(4'h5) or s_take(4'h7))
        |=> !rsp_valid_o [*2] ##[1:2] rsp_valid_o)
        else $error("response start wrong");
    chk_busy_hold: assert property (
        (s_take(4'h4) or s_take(4'h5) or s_take(4'h7))
        |=> rsp_busy_o [*3])
        else $error("busy not raised for response");
    chk_opc_done: assert property (
        s_take(4'h9) ##1 !ops_pending_i |-> ##[1:3] esr_o[0])
        else $error("operation complete not set");
endmodule : cch_core_monitor

bind cch_core cch_core_monitor u_mon (
    .clk_i, .resetn_i, .cmd_valid_i, .cmd_code_i, .cmd_arg_i,
    .ev_req_ctrl_i, .ev_query_err_i, .ev_dev_err_i, .ev_exec_err_i,
    .ev_cmd_err_i, .ops_pending_i, .rsp_valid_o, .rsp_busy_o, .esr_o,
    .ese_o, .esb_o, .status_clear_o, .dev_clear_o, .panel_lock_o);

`default_nettype wire

// *** cch_host_model.sv ***
/*
 * Remote controller model: issues decoded commands and gathers the
 * response bytes. Assumes one clock; the bench calls its tasks.
 */
`timescale 1ns/1ps
`default_nettype none

module cch_host_model (
    // Clock
    input  wire logic       clk_i,
    // Command side
    output var  logic       cmd_valid_o,
    output var  logic [3:0] cmd_code_o,
    output var  logic [7:0] cmd_arg_o,
    // Response side
    input  wire logic       rsp_valid_i,
    input  wire logic [7:0] rsp_data_i,
    input  wire logic       rsp_last_i
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o  = 4'h0;
        cmd_arg_o   = 8'h00;
    end

    task automatic send(input logic [3:0] code, input logic [7:0] arg);
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_code_o  = code;
        cmd_arg_o   = arg;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        // Idle lines flip so a stale sample cannot pass
        cmd_code_o  = ~code;
        cmd_arg_o   = ~arg;
    endtask : send

    task automatic ask(input logic [3:0] code, output string s,
                       output bit ok);
        s  = "";
        ok = 1'b0;
        send(code, 8'h00);
        for (int i = 0; i < 40 && !ok; i++) begin
            if (rsp_valid_i === 1'b1) begin
                s  = $sformatf("%s%c", s, rsp_data_i);
                ok = (rsp_last_i === 1'b1);
            end
            if (!ok) begin
                @(posedge clk_i);
                #1;
            end
        end
        // Gap so the next command is not dropped; leave off the edge
        @(posedge clk_i);
        #1;
    endtask : ask
endmodule : cch_host_model

`default_nettype wire

// *** cch_pkg.sv ***
/*
 * Package for the common command and status handler: command codes,
 * event register bit positions, reset values and response framing.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package cch_pkg;

    // ----------------------------------------------------------------
    // Command codes (star form and native form decode to the same code)
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        CCH_CMD_NONE = 4'h0,
        CCH_CMD_CLS  = 4'h1,
        CCH_CMD_DCL  = 4'h2,
        CCH_CMD_ESE  = 4'h3,
        CCH_CMD_ESEQ = 4'h4,
        CCH_CMD_ESRQ = 4'h5,
        CCH_CMD_GTL  = 4'h6,
        CCH_CMD_IDNQ = 4'h7,
        CCH_CMD_LLO  = 4'h8,
        CCH_CMD_OPC  = 4'h9,
        CCH_CMD_RST  = 4'hA
    } cch_cmd_t;

    // ----------------------------------------------------------------
    // Standard event register bit positions
    // ----------------------------------------------------------------
    localparam int CCH_EV_OPC = 0;
    localparam int CCH_EV_RQC = 1;
    localparam int CCH_EV_QYE = 2;
    localparam int CCH_EV_DDE = 3;
    localparam int CCH_EV_EXE = 4;
    localparam int CCH_EV_CME = 5;
    localparam int CCH_EV_PON = 7;

    localparam int         CCH_STB_ESB     = 5;
    localparam logic [7:0] CCH_ESR_RST     = 8'h80;
    localparam logic [7:0] CCH_ESE_RST     = 8'h00;
    localparam logic [7:0] CCH_BYTE_ZERO   = 8'h00;
    localparam logic [7:0] CCH_ASCII_COMMA = 8'h2C;
    localparam logic [7:0] CCH_ASCII_ZERO  = 8'h30;
    localparam logic [3:0] CCH_DEC_TEN     = 4'hA;
    localparam logic [7:0] CCH_DEC_HUNDRED = 8'h64;
    localparam logic [7:0] CCH_DEC_TENS    = 8'h0A;

    // ----------------------------------------------------------------
    // Identity fields (values arbitrary, fixed length per field)
    // ----------------------------------------------------------------
    localparam int CCH_ID_FIELD_LEN = 4;
    localparam int CCH_ID_FIELDS    = 4;

    // Response sequencer states
    typedef enum logic [1:0] {
        CCH_RS_IDLE = 2'b00,
        CCH_RS_NUM  = 2'b01,
        CCH_RS_ID   = 2'b10
    } cch_rsp_state_t;

endpackage : cch_pkg

`default_nettype wire

// *** cch_rsp_fmt.sv ***
/*
 * Response formatter: turns an 8-bit value into decimal ASCII digits,
 * or streams the comma separated identity string.
 * Assumes start is a single-cycle pulse given only while not busy.
 */
`timescale 1ns/1ps
`default_nettype none

module cch_rsp_fmt #(
    parameter logic [8*cch_pkg::CCH_ID_FIELD_LEN*cch_pkg::CCH_ID_FIELDS-1:0]
        ID_STR = "MFGRMODLSERN0100"
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Formatter side
    cch_rsp_if.fmt    rsp
);
    localparam int IDN = cch_pkg::CCH_ID_FIELD_LEN * cch_pkg::CCH_ID_FIELDS;

    cch_pkg::cch_rsp_state_t state_r;
    logic [4:0]              idx_r;
    logic [7:0]              val_r;
    logic [1:0]              dig_r;
    logic [7:0]              hund;
    logic [7:0]              tens;
    logic [7:0]              ones;
    logic [4:0]              id_pos;

    always_comb begin
        hund = val_r / cch_pkg::CCH_DEC_HUNDRED;
        tens = (val_r % cch_pkg::CCH_DEC_HUNDRED) / cch_pkg::CCH_DEC_TENS;
        ones = val_r % cch_pkg::CCH_DEC_TENS;
        id_pos = idx_r - (idx_r / 5'd5);
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_r        <= cch_pkg::CCH_RS_IDLE;
            idx_r          <= 5'h00;
            val_r          <= cch_pkg::CCH_BYTE_ZERO;
            dig_r          <= 2'h0;
            rsp.byte_valid <= 1'b0;
            rsp.byte_data  <= cch_pkg::CCH_BYTE_ZERO;
            rsp.last       <= 1'b0;
        end else begin
            rsp.byte_valid <= 1'b0;
            rsp.last       <= 1'b0;
            case (state_r)
                cch_pkg::CCH_RS_IDLE: begin
                    idx_r <= 5'h00;
                    if (rsp.start) begin
                        val_r <= rsp.value;
                        // Leading zeros suppressed; zero still sends "0"
                        dig_r <= (rsp.value >= cch_pkg::CCH_DEC_HUNDRED) ?
                                 2'h2 :
                                 (rsp.value >= cch_pkg::CCH_DEC_TENS) ?
                                 2'h1 : 2'h0;
                        state_r <= rsp.is_id ? cch_pkg::CCH_RS_ID
                                             : cch_pkg::CCH_RS_NUM;
                    end
                end
                cch_pkg::CCH_RS_NUM: begin
                    rsp.byte_valid <= 1'b1;
                    case (dig_r)
                        2'h2:    rsp.byte_data <= cch_pkg::CCH_ASCII_ZERO + hund;
                        2'h1:    rsp.byte_data <= cch_pkg::CCH_ASCII_ZERO + tens;
                        default: rsp.byte_data <= cch_pkg::CCH_ASCII_ZERO + ones;
                    endcase
                    if (dig_r == 2'h0) begin
                        rsp.last <= 1'b1;
                        state_r  <= cch_pkg::CCH_RS_IDLE;
                    end else begin
                        dig_r <= dig_r - 2'h1;
                    end
                end
                cch_pkg::CCH_RS_ID: begin
                    rsp.byte_valid <= 1'b1;
                    if ((idx_r % 5'd5) == 5'd4) begin
                        rsp.byte_data <= cch_pkg::CCH_ASCII_COMMA;
                    end else begin
                        rsp.byte_data <= ID_STR[8*(IDN-1-32'(id_pos)) +: 8];
                    end
                    if (idx_r == 5'(IDN + cch_pkg::CCH_ID_FIELDS - 2)) begin
                        rsp.last <= 1'b1;
                        state_r  <= cch_pkg::CCH_RS_IDLE;
                    end else begin
                        idx_r <= idx_r + 5'h01;
                    end
                end
                default: state_r <= cch_pkg::CCH_RS_IDLE;
            endcase
        end
    end

    // Start is left out: it depends on busy upstream, a loop otherwise
    assign rsp.busy = (state_r != cch_pkg::CCH_RS_IDLE);

endmodule : cch_rsp_fmt

`default_nettype wire

// *** cch_rsp_if.sv ***
/*
 * Interface carrying response bytes from the response formatter to the
 * command handler top. Assumes a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface cch_rsp_if;
    logic       start;
    logic       is_id;
    logic [7:0] value;
    logic       busy;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       last;

    modport ctrl (output start, output is_id, output value,
                  input busy, input byte_valid, input byte_data,
                  input last);
    modport fmt  (input start, input is_id, input value,
                  output busy, output byte_valid, output byte_data,
                  output last);
endinterface : cch_rsp_if

`default_nettype wire

// *** cch_tb.sv ***
/*
 * Self-checking bench for the command and status handler.
 * Assumes the checker and host model files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic         clk_i = 1'b0;
    logic         resetn;
    logic [4:0]   ev;
    logic         ops_pending;
    logic         err_push;
    logic         cmd_valid;
    logic [3:0]   cmd_code;
    logic [7:0]   cmd_arg;
    logic         rsp_valid;
    logic         rsp_last;
    logic [7:0]   rsp_data;
    logic [7:0]   esr;
    logic [7:0]   ese;
    logic         esb;
    logic         lock;
    logic [4:0]   err_count;
    int           mismatches = 0;
    int           num_checks = 0;
    logic [7:0]   tbl [4] = '{8'hC1, 8'h00, 8'hFF, 8'h05};

    always #50 clk_i = ~clk_i;

    cch_core dut (
        .clk_i(clk_i), .resetn_i(resetn), .cmd_valid_i(cmd_valid),
        .cmd_code_i(cmd_code), .cmd_arg_i(cmd_arg),
        .ev_req_ctrl_i(ev[0]), .ev_query_err_i(ev[1]),
        .ev_dev_err_i(ev[2]), .ev_exec_err_i(ev[3]), .ev_cmd_err_i(ev[4]),
        .ops_pending_i(ops_pending), .err_push_i(err_push),
        .ques_evt_i(1'b0), .oper_evt_i(1'b0), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .rsp_last_o(rsp_last), .rsp_busy_o(),
        .esr_o(esr), .ese_o(ese), .esb_o(esb), .err_count_o(err_count),
        .status_clear_o(), .dev_clear_o(), .panel_lock_o(lock));

    cch_host_model host (
        .clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
        .cmd_arg_o(cmd_arg), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .rsp_last_i(rsp_last));

    task automatic stop_test;
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic q(logic [3:0] c, string e);
        string s;
        bit    ok;
        host.ask(c, s, ok);
        num_checks++;
        if (!ok || s != e) begin
            mismatches++;
            $display("BAD reply %h expected %s seen %s", c, e, s);
        end
        if (!ok) begin
            stop_test();
        end
    endtask : q

    task automatic idle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    task automatic power_on;
        resetn = 1'b0;
        idle(16);
        resetn = 1'b1;
    endtask : power_on

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        ev          = 5'h00;
        ops_pending = 1'b0;
        err_push    = 1'b0;
        power_on();
        cmp("ese", 8'h00, ese);
        cmp("esr", 8'h80, esr);
        q(4'h5, "128");
        idle(3);
        cmp("esr", 8'h00, esr);
        foreach (tbl[i]) begin
            host.send(4'h3, tbl[i]);
            idle(3);
            cmp("ese", tbl[i], ese);
            q(4'h4, $sformatf("%0d", tbl[i]));
        end
        host.send(4'hA, 8'h00);
        idle(3);
        cmp("ese", 8'h05, ese);
        for (int b = 0; b < 5; b++) begin
            host.send(4'h3, 8'h02 << b);
            idle(3);
            cmp("esb", 8'h00, {7'h00, esb});
            ev[b] = 1'b1;
            idle(1);
            ev    = 5'h00;
            idle(3);
            cmp("esr", 8'h02 << b, esr);
            cmp("esb", 8'h01, {7'h00, esb});
            q(4'h5, $sformatf("%0d", 2 << b));
        end
        ev[3] = 1'b1;
        repeat (3) begin
            err_push = 1'b1;
            idle(1);
            err_push = 1'b0;
            ev       = 5'h00;
            idle(1);
        end
        idle(2);
        cmp("errq", 8'h03, {3'h0, err_count});
        host.send(4'h1, 8'h00);
        idle(3);
        cmp("esr", 8'h00, esr);
        cmp("errq", 8'h00, {3'h0, err_count});
        ops_pending = 1'b1;
        host.send(4'h9, 8'h00);
        idle(4);
        cmp("esr", 8'h00, esr);
        ops_pending = 1'b0;
        idle(4);
        cmp("esr", 8'h01, esr);
        q(4'h5, "1");
        host.send(4'h9, 8'h00);
        idle(4);
        q(4'h5, "1");
        host.send(4'h8, 8'h00);
        idle(3);
        cmp("lock", 8'h01, {7'h00, lock});
        host.send(4'h6, 8'h00);
        idle(3);
        cmp("lock", 8'h00, {7'h00, lock});
        host.send(4'h8, 8'h00);
        idle(3);
        host.send(4'h2, 8'h00);
        idle(3);
        cmp("lock", 8'h00, {7'h00, lock});
        q(4'h7, "MFGR,MODL,SERN,0100");
        host.send(4'h3, 8'h5A);
        idle(3);
        cmp("ese", 8'h5A, ese);
        power_on();
        cmp("ese", 8'h00, ese);
        cmp("esr", 8'h80, esr);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
